// *** hdl/dma_event_channel_selector.sv ***
// Routes peripheral events onto DMA channel trigger inputs.
// How it works
// [R1] Sixteen channel triggers; 8 to 11 follow the chaining codes only.
// [R2] Selector registers sit at 0x01A0FF00, 0x01A0FF04 and 0x01A0FF0C.
// [R3] Each remappable trigger follows the event whose code is loaded.
// [R4] Fields sit at [5:0],[13:8],[21:16],[29:24], lowest channel low.
// [R5] Codes map to timers, refresh, GPIO 4-7 and 2, serial tx/rx.
// [R6] Reserved codes, zero, 0x08, 0x09, 0x0B or 0x10 and above, give no event.
// [R7] Bits 31:30, 23:22, 15:14 and 7:6 read as zero and ignore writes.
// [R8] Channels 0 to 7 reset to codes equal to their channel number.
// [R9] Channels 12 to 15 reset to codes 0x0C through 0x0F.
// [R10] GPIO events 4 to 7 come from the GPIO block's pins 4 to 7.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
module dma_event_channel_selector (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [31:0]          adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    output logic                      err_o,
    input  wire logic                 timer_zero_event_i,
    input  wire logic                 timer_one_event_i,
    input  wire logic                 memory_refresh_event_i,
    input  wire logic [3:0]           gpio_pin_event_i,
    input  wire logic                 gpio_pin_event_two_i,
    input  wire logic                 serial0_tx_event_i,
    input  wire logic                 serial0_rx_event_i,
    input  wire logic                 serial1_tx_event_i,
    input  wire logic                 serial1_rx_event_i,
    input  wire logic [event_select_pkg::CHAIN_N-1:0]
                                      chain_completion_code_i,
    output logic [event_select_pkg::CHANNELS-1:0]
                                      channel_trigger_o
);
    import event_select_pkg::*;

    // ------------------------------------------------------------------
    // Register storage and bus decode
    // ------------------------------------------------------------------
    logic [31:0] sel_q [3];
    logic [31:0] sel_d [3];
    logic [31:0] rd_d;
    logic        ack_q;
    logic        err_q;
    logic [31:0] dat_q;
    logic [31:0] lane_mask;
    wire         req      = cyc_i && stb_i && !ack_q && !err_q;
    wire         hit0     = (adr_i == SEL_CH0_3_ADDR);    // [R2]
    wire         hit1     = (adr_i == SEL_CH4_7_ADDR);    // [R2]
    wire         hit3     = (adr_i == SEL_CH12_15_ADDR);  // [R2]
    wire         hit_any  = hit0 || hit1 || hit3;
    wire [2:0]   hit_vec  = {hit3, hit1, hit0};

    // Byte enables widen to a bit mask; reserved bits never take data.
    assign lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                        {8{sel_i[1]}}, {8{sel_i[0]}}} & FIELD_MASK; // [R7]

    // Next register values: only the addressed word changes, and only
    // in its field bits under the enabled byte lanes.
    genvar r;
    generate
        for (r = 0; r < 3; r++) begin : g_reg
            assign sel_d[r] = (req && we_i && hit_vec[r])
                ? ((sel_q[r] & ~lane_mask) | (dat_i & lane_mask))
                : sel_q[r]; // [R4] [R7]
        end
    endgenerate

    // Read mux; the storage never holds reserved bits so they read zero.
    assign rd_d = hit0 ? sel_q[0] : hit1 ? sel_q[1] :
                  hit3 ? sel_q[2] : 32'h00000000; // [R7]

    // Registers load their default codes on reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_q[0] <= SEL_CH0_3_RST;   // [R8]
            sel_q[1] <= SEL_CH4_7_RST;   // [R8]
            sel_q[2] <= SEL_CH12_15_RST; // [R9]
        end else begin
            sel_q[0] <= sel_d[0];
            sel_q[1] <= sel_d[1];
            sel_q[2] <= sel_d[2];
        end
    end

    // Bus answer one cycle after the request; unmapped addresses err.
    // The gap at 0x01A0FF08 errs too, since no register lives there.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req && hit_any;
            err_q <= req && !hit_any; // [R2]
            dat_q <= (req && !we_i) ? rd_d : 32'h00000000;
        end
    end

    assign ack_o = ack_q;
    assign err_o = err_q;
    assign dat_o = dat_q;

    // ------------------------------------------------------------------
    // Event source table indexed by selector code
    // ------------------------------------------------------------------
    logic [SRC_N-1:0] src_vec;
    always_comb begin
        src_vec = '0; // [R6]
        src_vec[CODE_TIMER0]  = timer_zero_event_i;     // [R5]
        src_vec[CODE_TIMER1]  = timer_one_event_i;      // [R5]
        src_vec[CODE_REFRESH] = memory_refresh_event_i; // [R5]
        src_vec[CODE_GPIO4]   = gpio_pin_event_i[0];    // [R10]
        src_vec[CODE_GPIO5]   = gpio_pin_event_i[1];    // [R10]
        src_vec[CODE_GPIO6]   = gpio_pin_event_i[2];    // [R10]
        src_vec[CODE_GPIO7]   = gpio_pin_event_i[3];    // [R10]
        src_vec[CODE_GPIO2]   = gpio_pin_event_two_i;   // [R5]
        src_vec[CODE_SER0_TX] = serial0_tx_event_i;     // [R5]
        src_vec[CODE_SER0_RX] = serial0_rx_event_i;     // [R5]
        src_vec[CODE_SER1_TX] = serial1_tx_event_i;     // [R5]
        src_vec[CODE_SER1_RX] = serial1_rx_event_i;     // [R5]
    end

    // ------------------------------------------------------------------
    // Per-channel routing
    // ------------------------------------------------------------------
    // Sources are same-clock logic, so they are not synchronised; the
    // trigger is registered so each output comes from a flop, adding
    // one cycle of latency to every event.
    logic [CHANNELS-1:0] trig_d;
    logic [CHANNELS-1:0] trig_q;
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            if (c >= CHAIN_FIRST && c <= CHAIN_LAST) begin : g_chain
                assign trig_d[c] =
                    chain_completion_code_i[c-CHAIN_FIRST]; // [R1]
            end else begin : g_map
                localparam int REG = (c < CHAIN_FIRST) ? c / FIELDS : 2;
                localparam int LO  = (c % FIELDS) * FIELD_PITCH;
                wire [CODE_W-1:0] code =
                    sel_q[REG][LO +: CODE_W]; // [R4]
                assign trig_d[c] = src_vec[code]; // [R3] [R6]
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_q <= '0;
        end else begin
            trig_q <= trig_d; // [R3]
        end
    end

    assign channel_trigger_o = trig_q;

endmodule : dma_event_channel_selector

// *** hdl/event_select_pkg.sv ***
// Constants for the DMA event channel selector.
package event_select_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] SEL_CH0_3_ADDR   = 32'h01A0FF00;
    localparam logic [31:0] SEL_CH4_7_ADDR   = 32'h01A0FF04;
    localparam logic [31:0] SEL_CH12_15_ADDR = 32'h01A0FF0C;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int CHANNELS    = 16;
    localparam int CODE_W      = 6;
    localparam int FIELD_PITCH = 8;
    localparam int FIELDS      = 4;
    localparam int CHAIN_FIRST = 8;
    localparam int CHAIN_LAST  = 11;
    localparam int CHAIN_N     = 4;
    localparam int SRC_N       = 64;

    // ------------------------------------------------------------------
    // Selector codes
    // ------------------------------------------------------------------
    localparam logic [5:0] CODE_TIMER0   = 6'h01;
    localparam logic [5:0] CODE_TIMER1   = 6'h02;
    localparam logic [5:0] CODE_REFRESH  = 6'h03;
    localparam logic [5:0] CODE_GPIO4    = 6'h04;
    localparam logic [5:0] CODE_GPIO5    = 6'h05;
    localparam logic [5:0] CODE_GPIO6    = 6'h06;
    localparam logic [5:0] CODE_GPIO7    = 6'h07;
    localparam logic [5:0] CODE_GPIO2    = 6'h0A;
    localparam logic [5:0] CODE_SER0_TX  = 6'h0C;
    localparam logic [5:0] CODE_SER0_RX  = 6'h0D;
    localparam logic [5:0] CODE_SER1_TX  = 6'h0E;
    localparam logic [5:0] CODE_SER1_RX  = 6'h0F;

    // ------------------------------------------------------------------
    // Reset values of the three selector registers
    // ------------------------------------------------------------------
    localparam logic [31:0] SEL_CH0_3_RST   = 32'h03020100;
    localparam logic [31:0] SEL_CH4_7_RST   = 32'h07060504;
    localparam logic [31:0] SEL_CH12_15_RST = 32'h0F0E0D0C;

    // Bits of each register that hold selector fields.
    localparam logic [31:0] FIELD_MASK = 32'h3F3F3F3F;

endpackage : event_select_pkg

// *** test/dma_event_channel_selector_sva.sv ***
// Checker of the selector's bus answers and chain triggers.
`timescale 1ns/10ps
module dma_event_channel_selector_sva
    import event_select_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        err_o,
    input wire logic [3:0]  chain_completion_code_i,
    input wire logic [15:0] channel_trigger_o
);
    // A request is only taken while no answer is out.
    wire req = cyc_i && stb_i && !ack_o && !err_o;
    wire hit = adr_i == SEL_CH0_3_ADDR || adr_i == SEL_CH4_7_ADDR ||
               adr_i == SEL_CH12_15_ADDR;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_map_ack: assert property (req && hit |=> ack_o && !err_o)
        else $error("mapped request not acknowledged");
    a_hole_err: assert property (req && adr_i == 32'h01A0FF08 |=>
        err_o && !ack_o) else $error("hole address not refused");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_err_single: assert property (err_o |=> !err_o)
        else $error("err longer than one cycle");
    a_no_request: assert property (!(cyc_i && stb_i) |=>
        !ack_o && !err_o) else $error("answer without request");
    a_rsvd_zero: assert property (ack_o |->
        (dat_o & ~FIELD_MASK) == 32'h0) else $error("reserved bits set");
    a_chain_follow: assert property (!$past(rst_i) |->
        channel_trigger_o[11:8] == $past(chain_completion_code_i))
        else $error("chain trigger wrong");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
        channel_trigger_o == 16'h0 && !ack_o) else $error("reset not quiet");
    c_map: cover property (req && hit ##1 ack_o);
    c_err: cover property (err_o);
    c_trig: cover property (channel_trigger_o[15]);
endmodule : dma_event_channel_selector_sva

bind dma_event_channel_selector dma_event_channel_selector_sva u_sva (
    .clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .dat_o, .ack_o, .err_o,
    .chain_completion_code_i, .channel_trigger_o);

// *** test/event_source_model.sv ***
// Random peripheral event and chaining code sources for the bench.
`timescale 1ns/10ps
module event_source_model (
    input  wire logic        clk_i,
    output logic      [15:0] event_o
);
    // New levels each cycle, so single pulses and held levels both occur.
    // A single process drives the output; it is unknown only until the
    // first edge, which still falls inside reset.
    always @(posedge clk_i) begin
        event_o <= 16'($urandom);
    end
endmodule : event_source_model

// *** test/tb_dma_event_channel_selector.sv ***
// Self-checking bench of the selector against a register and route model.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_dma_event_channel_selector import event_select_pkg::*;;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, rd;
    logic [3:0]  sel = 4'h0;
    logic        ack, err;
    logic [15:0] ev, trig, prev;
    logic [31:0] mr [4] = '{SEL_CH0_3_RST, SEL_CH4_7_RST, 32'h0,
                            SEL_CH12_15_RST};
    int          fails = 0, num_checks = 0;
    event_source_model src (.clk_i(clk), .event_o(ev));
    dma_event_channel_selector dut (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack),
        .err_o(err), .timer_zero_event_i(ev[0]), .timer_one_event_i(ev[1]),
        .memory_refresh_event_i(ev[2]), .gpio_pin_event_i(ev[6:3]),
        .gpio_pin_event_two_i(ev[7]), .serial0_tx_event_i(ev[8]),
        .serial0_rx_event_i(ev[9]), .serial1_tx_event_i(ev[10]),
        .serial1_rx_event_i(ev[11]), .chain_completion_code_i(ev[15:12]),
        .channel_trigger_o(trig));
    always #25 clk = ~clk;
    // Event that a code selects; reserved codes select nothing.
    function automatic logic route(input logic [5:0] c, input logic [15:0] e);
        if (c >= 6'h01 && c <= 6'h07) return e[c - 1];
        if (c == 6'h0A) return e[7];
        if (c >= 6'h0C && c <= 6'h0F) return e[c - 4];
        return 1'b0;
    endfunction : route
    function automatic logic [15:0] expect_trig(input logic [15:0] e);
        logic [15:0] t;
        for (int ch = 0; ch < 16; ch++)
            t[ch] = (ch >= 8 && ch <= 11) ? e[ch + 4]
                  : route(mr[ch / 4][8 * (ch % 4) +: 6], e);
        return t;
    endfunction : expect_trig
    // Classic cycle; waits for ack or err under a bound, then releases.
    task automatic bus(input logic w, input int i, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, 32'(32'h01A0FF00 + 4 * i),
                                          d, s};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        r = rd;
        e = err;
        {cyc, stb} <= 2'b00;
        if (n >= 20) fails++;
    endtask : bus
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial begin
        logic [31:0] r, d;
        logic [3:0]  s;
        logic        e;
        void'($urandom(7189));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset contents, and the hole at the third word.
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, i, 32'h0, 4'hF, r, e);
            `CHK(e, i == 2)
            if (i != 2) `CHK(r, mr[i])
        end
        // Random lane writes; only the low six bits of each byte stick.
        repeat (16) begin
            int i;
            i = $urandom % 4;
            d = $urandom;
            s = 4'($urandom);
            bus(1'b1, i, d, s, r, e);
            `CHK(e, i == 2)
            for (int b = 0; b < 4; b++)
                if (s[b] && i != 2) mr[i][8 * b +: 8] = d[8 * b +: 8] & 8'h3F;
            bus(1'b0, i, 32'h0, 4'hF, r, e);
            `CHK(r, mr[i])
        end
        // Every code in every field, distinct per field, under live events.
        for (int c = 0; c < 64; c++) begin
            d = {2'b00, 6'(c + 3), 2'b00, 6'(c + 2), 2'b00, 6'(c + 1),
                 2'b00, 6'(c)};
            for (int i = 0; i < 4; i++)
                if (i != 2) begin
                    bus(1'b1, i, d, 4'hF, r, e);
                    mr[i] = d;
                end
            @(negedge clk);
            repeat (6) begin
                prev = ev;
                @(negedge clk);
                `CHK(trig, expect_trig(prev))
            end
        end
        report_and_stop();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule : tb_dma_event_channel_selector
